/* verilog/hleh_error_handler.sv */
// Link error handler: frame checks, timeout, error indication
`timescale 1ns/10ps
`default_nettype none

module hleh_error_handler #(
   parameter int unsigned DEPTH = hleh_pkg::BUF_DEPTH,
   parameter int unsigned TIMEOUT_CYCLES = hleh_pkg::TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic auto_reset,
   input wire logic key_press,
   input wire hleh_pkg::hleh_line_cfg_s line_cfg_in,
   output hleh_pkg::hleh_line_cfg_s line_cfg,
   input wire hleh_pkg::hleh_rx_char_s rx,
   input wire logic tx_start,
   output logic rx_hold,
   output logic cmd_valid,
   output logic [$clog2(DEPTH+1)-1:0] cmd_len,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [7:0] rd_data,
   output logic err_event,
   output hleh_pkg::hleh_err_s err_last,
   output hleh_pkg::hleh_dir_e err_last_dir,
   output logic err_show,
   output hleh_pkg::hleh_err_s err_flags,
   output hleh_pkg::hleh_dir_e err_dir
);
   import hleh_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] HOLD_C = CW'(DEPTH - HOLD_MARGIN);
   localparam logic [TW-1:0] TLIM_C = TW'(TIMEOUT_CYCLES);

   if (DEPTH < MIN_LEN + HOLD_MARGIN || TIMEOUT_CYCLES < 1) begin : g_chk
      $error("DEPTH or TIMEOUT_CYCLES too small");
   end

   // Frame state
   hleh_frame_e fst_q, fst_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [7:0] fcs_q, fcs_d;
   logic [TW-1:0] tmr_q, tmr_d;
   logic [7:0] unit_q, unit_d;
   logic [7:0] code_q, code_d;
   logic [7:0] buf_q [DEPTH];
   logic wr_en;
   logic char_bad;
   logic start_rx;
   logic done_ok;
   hleh_err_s new_err;
   hleh_dir_e new_dir;

   always_comb begin
      fst_d = fst_q;
      cnt_d = cnt_q;
      fcs_d = fcs_q;
      tmr_d = tmr_q;
      unit_d = unit_q;
      code_d = code_q;
      wr_en = 1'b0;
      done_ok = 1'b0;
      new_err = '0;
      new_dir = (fst_q == F_SEND) ? HLEH_DIR_SEND : HLEH_DIR_RECV;
      char_bad = rx.valid & (rx.parity_err | rx.framing_err | rx.overrun_err);
      new_err.parity = rx.valid & rx.parity_err;
      new_err.framing = rx.valid & rx.framing_err;
      new_err.overrun = rx.valid & rx.overrun_err;
      start_rx = rx.valid & ~char_bad & (rx.data == START_CHAR) & (fst_q == F_IDLE || fst_q == F_SEND);
      if (fst_q == F_SEND || fst_q == F_RECV) begin
         tmr_d = tmr_q + TW'(1);
      end
      unique case (fst_q)
         F_IDLE: begin
            if (tx_start && !start_rx) begin
               fst_d = F_SEND;
            end
         end
         F_SEND: begin
            if (tmr_q >= TLIM_C) begin
               new_err.timeout = 1'b1;
               fst_d = F_IDLE;
            end else if (char_bad) begin
               fst_d = F_DROP;
            end
         end
         F_RECV: begin
            if (tmr_q >= TLIM_C) begin
               new_err.timeout = 1'b1;
               fst_d = F_IDLE;
            end else if (char_bad) begin
               fst_d = F_DROP;
            end else if (rx.valid && rx.data == END_CHAR) begin
               fst_d = F_IDLE;
               new_err.fcs = (fcs_q != FCS_RESET) || (cnt_q < CW'(MIN_LEN));
               if (cnt_q >= CW'(MIN_LEN)) begin
                  new_err.unit = (unit_q != UNIT_EXPECTED);
                  new_err.nack = (code_q != ACK_CODE);
               end
               done_ok = ~new_err.fcs & ~new_err.unit & ~new_err.nack;
            end else if (rx.valid && cnt_q == DEPTH_C) begin
               new_err.buf_ovf = 1'b1;
               fst_d = F_DROP;
            end else if (rx.valid) begin
               wr_en = 1'b1;
               cnt_d = cnt_q + CW'(1);
               fcs_d = fcs_q ^ rx.data;
               if (cnt_q == CW'(POS_UNIT)) begin
                  unit_d = rx.data;
               end
               if (cnt_q == CW'(POS_CODE)) begin
                  code_d = rx.data;
               end
            end
         end
         F_DROP: begin
            if (rx.valid && !char_bad && rx.data == END_CHAR) begin
               fst_d = F_IDLE;
            end
         end
      endcase
      if (start_rx) begin
         fst_d = F_RECV;
         wr_en = 1'b1;
         cnt_d = CW'(1);
         fcs_d = rx.data;
         tmr_d = '0;
      end
      if (fst_d == F_IDLE || fst_d == F_DROP || (fst_q == F_IDLE && fst_d == F_SEND)) begin
         tmr_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fst_q <= F_IDLE;
         cnt_q <= '0;
         fcs_q <= FCS_RESET;
         tmr_q <= '0;
         unit_q <= '0;
         code_q <= '0;
      end else begin
         fst_q <= fst_d;
         cnt_q <= cnt_d;
         fcs_q <= fcs_d;
         tmr_q <= tmr_d;
         unit_q <= unit_d;
         code_q <= code_d;
      end
   end

   // Receive buffer storage
   always_ff @(posedge clk) begin
      if (wr_en) begin
         buf_q[start_rx ? AW'(0) : cnt_q[AW-1:0]] <= rx.data;
      end
      rd_data <= buf_q[rd_idx];
   end

   // Command and event outputs
   logic cmd_valid_d;
   logic [CW-1:0] cmd_len_d;
   logic rx_hold_d;
   hleh_line_cfg_s line_cfg_d;
   logic err_event_d;
   hleh_err_s err_last_d;
   hleh_dir_e err_last_dir_d;

   always_comb begin
      cmd_valid_d = done_ok;
      cmd_len_d = done_ok ? cnt_q : cmd_len;
      rx_hold_d = line_cfg.flow & (cnt_d >= HOLD_C) & (fst_d == F_RECV);
      line_cfg_d = (fst_q == F_IDLE) ? line_cfg_in : line_cfg;
      err_event_d = hleh_any(new_err);
      err_last_d = err_event_d ? new_err : err_last;
      err_last_dir_d = err_event_d ? new_dir : err_last_dir;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_valid <= 1'b0;
         cmd_len <= '0;
         rx_hold <= 1'b0;
         line_cfg <= LINE_CFG_RESET;
         err_event <= 1'b0;
         err_last <= '0;
         err_last_dir <= HLEH_DIR_RECV;
      end else begin
         cmd_valid <= cmd_valid_d;
         cmd_len <= cmd_len_d;
         rx_hold <= rx_hold_d;
         line_cfg <= line_cfg_d;
         err_event <= err_event_d;
         err_last <= err_last_d;
         err_last_dir <= err_last_dir_d;
      end
   end

   // Error indication
   hleh_ind_e ind_q, ind_d;
   hleh_err_s shown;
   hleh_err_s flags_d;
   hleh_dir_e dir_d;

   always_comb begin
      shown = hleh_gate(new_err, auto_reset ? AUTO_SHOWN : ALL_SHOWN);
      ind_d = ind_q;
      flags_d = err_flags;
      dir_d = err_dir;
      unique case (ind_q)
         I_RUN: begin
            if (hleh_any(shown)) begin
               ind_d = I_SHOW;
            end
         end
         I_SHOW: begin
            if (key_press) begin
               ind_d = hleh_any(shown) ? I_SHOW : I_RUN;
               flags_d = '0;
            end
         end
      endcase
      if (hleh_any(shown) && (ind_q == I_RUN || key_press)) begin
         dir_d = new_dir;
      end
      flags_d = hleh_err_s'(flags_d | shown);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ind_q <= I_RUN;
         err_flags <= '0;
         err_dir <= HLEH_DIR_RECV;
      end else begin
         ind_q <= ind_d;
         err_flags <= flags_d;
         err_dir <= dir_d;
      end
   end

   assign err_show = (ind_q == I_SHOW);

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence frame_end_s;
      fst_q == F_RECV && rx.valid && !char_bad && rx.data == END_CHAR && tmr_q < TLIM_C;
   endsequence

   sequence key_clear_s;
      err_show && key_press && !hleh_any(shown);
   endsequence

   parity_flag_a: assert property (rx.valid && rx.parity_err |=> err_event && err_last.parity)
      else $error("parity error not reported");
   dir_class_a: assert property (hleh_any(new_err) && fst_q == F_SEND |=> err_last_dir == HLEH_DIR_SEND)
      else $error("send error classified wrongly");
   no_exec_a: assert property (err_event |-> !cmd_valid)
      else $error("errored command executed");
   fcs_drop_a: assert property (frame_end_s ##0 (fcs_q != FCS_RESET) |=> !cmd_valid && err_last.fcs)
      else $error("bad check sequence accepted");
   timeout_a: assert property (fst_q inside {F_SEND, F_RECV} && tmr_q == TLIM_C |=> err_event && err_last.timeout)
      else $error("timeout not raised");
   overflow_a: assert property (fst_q == F_RECV && rx.valid && !char_bad && rx.data != END_CHAR
                                && cnt_q == DEPTH_C && tmr_q < TLIM_C |=> err_last.buf_ovf && fst_q == F_DROP)
      else $error("buffer overflow missed");
   unit_chk_a: assert property (frame_end_s ##0 cnt_q >= CW'(MIN_LEN) && unit_q != UNIT_EXPECTED |=> err_last.unit)
      else $error("unit mismatch missed");
   cfg_apply_a: assert property (fst_q != F_IDLE |=> $stable(line_cfg))
      else $error("line settings changed mid frame");
   manual_show_a: assert property (err_event && !$past(auto_reset) |-> err_show)
      else $error("indication missing with recovery off");
   auto_show_a: assert property (err_event && (err_last.timeout || err_last.framing) |-> err_show)
      else $error("fault class not shown");
   key_clear_a: assert property (key_clear_s |=> !err_show && err_flags == '0)
      else $error("key press did not clear indication");
   nack_chk_a: assert property (frame_end_s ##0 cnt_q >= CW'(MIN_LEN) && code_q != ACK_CODE |=> err_last.nack)
      else $error("negative acknowledge missed");
   timer_stop_a: assert property (fst_q inside {F_IDLE, F_DROP} |-> tmr_q == '0)
      else $error("timer running outside frame");
   hold_flow_a: assert property (rx_hold |-> line_cfg.flow && $past(cnt_d) >= HOLD_C)
      else $error("hold without flow control");

endmodule

`default_nettype wire

/* common/hleh_pkg.sv */
// Constants, types and helpers shared by the link error handler
package hleh_pkg;

   // Clock and timeout figures
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TIMEOUT_S = 5;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;

   // Frame layout
   localparam logic [7:0] START_CHAR = 8'h40;
   localparam logic [7:0] END_CHAR = 8'h0d;
   localparam logic [7:0] UNIT_EXPECTED = 8'h00;
   localparam logic [7:0] ACK_CODE = 8'h00;
   localparam int unsigned POS_UNIT = 1;
   localparam int unsigned POS_CODE = 2;
   localparam int unsigned MIN_LEN = 4;

   // Receive buffer
   localparam int unsigned BUF_DEPTH = 32;
   localparam int unsigned HOLD_MARGIN = 4;

   // Reset values
   localparam logic [7:0] FCS_RESET = 8'h00;

   typedef struct packed {
      logic parity;
      logic framing;
      logic overrun;
      logic buf_ovf;
      logic timeout;
      logic nack;
      logic fcs;
      logic unit;
   } hleh_err_s;

   // Classes shown even under automatic recovery
   localparam hleh_err_s AUTO_SHOWN = '{parity: 1'b1, framing: 1'b1, overrun: 1'b1, buf_ovf: 1'b0,
                                       timeout: 1'b1, nack: 1'b0, fcs: 1'b0, unit: 1'b0};
   localparam hleh_err_s ALL_SHOWN = '{default: 1'b1};

   typedef enum logic {
      HLEH_DIR_RECV = 1'b0,
      HLEH_DIR_SEND = 1'b1
   } hleh_dir_e;

   typedef struct packed {
      logic [1:0] parity;
      logic data_bits;
      logic stop_bits;
      logic flow;
      logic [2:0] baud;
   } hleh_line_cfg_s;

   localparam hleh_line_cfg_s LINE_CFG_RESET = '0;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic parity_err;
      logic framing_err;
      logic overrun_err;
   } hleh_rx_char_s;

   typedef enum logic [3:0] {
      F_IDLE = 4'b0001,
      F_SEND = 4'b0010,
      F_RECV = 4'b0100,
      F_DROP = 4'b1000
   } hleh_frame_e;

   typedef enum logic [1:0] {
      I_RUN = 2'b01,
      I_SHOW = 2'b10
   } hleh_ind_e;

   function automatic logic hleh_any(input hleh_err_s e);
      hleh_any = |e;
   endfunction

   function automatic hleh_err_s hleh_gate(input hleh_err_s e, input hleh_err_s m);
      hleh_gate = hleh_err_s'(e & m);
   endfunction

endpackage

/* tb/hleh_host_model.sv */
// Host controller model driving the character stream
`timescale 1ns/10ps
`default_nettype none
module hleh_host_model (
   input wire logic clk,
   output hleh_pkg::hleh_rx_char_s rx
);
   import hleh_pkg::*;
   initial begin
      rx = '0;
   end
   // One char, launched at the falling edge, then an idle cycle
   task automatic send_char(input logic [7:0] d, input logic [2:0] e);
      @(negedge clk);
      rx = '{valid: 1'b1, data: d, parity_err: e[2], framing_err: e[1], overrun_err: e[0]};
      @(negedge clk);
      rx = '{valid: 1'b0, data: ~d, parity_err: 1'b0, framing_err: 1'b0, overrun_err: 1'b0};
   endtask
endmodule
`default_nettype wire

/* tb/tb_hleh_error_handler.sv */
// Self-checking bench for the link error handler
`timescale 1ns/10ps
`default_nettype none
module tb_hleh_error_handler;
   import hleh_pkg::*;
   localparam int unsigned DP = 8;
   localparam int unsigned TO = 50;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic auto_reset = 1'b0;
   logic key_press = 1'b0;
   logic tx_start = 1'b0;
   hleh_line_cfg_s line_cfg_in = '0;
   hleh_line_cfg_s line_cfg;
   hleh_rx_char_s rx;
   logic rx_hold, cmd_valid, err_event, err_show;
   logic [3:0] cmd_len;
   logic [2:0] rd_idx = '0;
   logic [7:0] rd_data;
   hleh_err_s err_last, err_flags;
   hleh_dir_e err_last_dir, err_dir;
   int bad_count = 0;
   int comparisons = 0;
   int ev_n = 0;
   int cv_n = 0;
   int cyc = 0;
   int e0, c0;
   logic hold_seen = 1'b0;
   logic [31:0] lfsr_q = 32'h79bcce74;
   logic [7:0] frm [$];

   always #25 clk = ~clk;

   hleh_error_handler #(.DEPTH(DP), .TIMEOUT_CYCLES(TO)) DUT (.clk(clk), .reset(reset),
      .auto_reset(auto_reset), .key_press(key_press), .line_cfg_in(line_cfg_in), .line_cfg(line_cfg),
      .rx(rx), .tx_start(tx_start), .rx_hold(rx_hold), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
      .rd_idx(rd_idx), .rd_data(rd_data), .err_event(err_event), .err_last(err_last),
      .err_last_dir(err_last_dir), .err_show(err_show), .err_flags(err_flags), .err_dir(err_dir));
   hleh_host_model host (.clk(clk), .rx(rx));

   task automatic wrap_up();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Pulse counters and hang guard
   always @(negedge clk) begin
      if (err_event === 1'b1) ev_n++;
      if (cmd_valid === 1'b1) cv_n++;
      if (rx_hold === 1'b1) hold_seen = 1'b1;
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      rnd = lfsr_q[7:0];
   endfunction

   task automatic mark();
      e0 = ev_n;
      c0 = cv_n;
   endtask

   // Frame of START, unit, code, data, check byte, END
   task automatic send_frame(input logic [7:0] u, input logic [7:0] c, input int n, input logic bad, input int gap);
      logic [7:0] x;
      frm = {START_CHAR, u, c};
      for (int i = 0; i < n; i++) frm.push_back(8'h80 | rnd());
      x = '0;
      foreach (frm[i]) x ^= frm[i];
      if ((x ^ {7'h0, bad}) == END_CHAR) begin
         frm.push_back(8'h81);
         x ^= 8'h81;
      end
      frm.push_back(x ^ {7'h0, bad});
      mark();
      foreach (frm[i]) begin
         host.send_char(frm[i], 3'b000);
         repeat (gap) @(negedge clk);
      end
      host.send_char(END_CHAR, 3'b000);
   endtask

   // Outcome after settling: accepted or one error of given classes
   task automatic expect_ev(input logic ok, input logic [7:0] e, input logic dir);
      repeat (3) @(negedge clk);
      #5;
      check(cv_n - c0, ok);
      check(ev_n - e0, !ok);
      if (!ok) check(err_last, e);
      if (!ok) check(err_last_dir, dir);
   endtask

   task automatic key();
      @(negedge clk) key_press = 1'b1;
      @(negedge clk) key_press = 1'b0;
      #5 check(err_show, 0);
      check(err_flags, 0);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      #5 check(err_show, 0);
      check(line_cfg, 0);
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) line_cfg_in = rnd();
         repeat (2) @(negedge clk);
         #5 check(line_cfg, line_cfg_in);
      end
      line_cfg_in.flow = 1'b1;
      // Clean frames, slow ones back to back exceed one timeout together
      for (int k = 0; k < 6; k++) begin
         send_frame(UNIT_EXPECTED, ACK_CODE, rnd() % 4, 1'b0, k % 3);
         expect_ev(1'b1, 8'h00, 1'b0);
         check(cmd_len, frm.size());
         for (int i = 0; i < frm.size(); i++) begin
            @(negedge clk) rd_idx = i[2:0];
            @(negedge clk);
            #5 check(rd_data, frm[i]);
         end
      end
      send_frame(8'h00, 8'h00, 2, 1'b1, 0);
      expect_ev(1'b0, 8'h02, 1'b0);
      check(err_show, 1);
      check(err_flags, 8'h02);
      key();
      send_frame(8'h05, 8'h00, 2, 1'b0, 0);
      expect_ev(1'b0, 8'h01, 1'b0);
      send_frame(8'h00, 8'h23, 2, 1'b0, 0);
      expect_ev(1'b0, 8'h04, 1'b0);
      check(err_flags, 8'h05);
      key();
      mark();
      host.send_char(START_CHAR, 3'b000);
      host.send_char(8'h00, 3'b000);
      host.send_char(END_CHAR, 3'b000);
      expect_ev(1'b0, 8'h02, 1'b0);
      key();
      // Char errors shown under automatic recovery
      auto_reset = 1'b1;
      for (int j = 0; j < 3; j++) begin
         mark();
         host.send_char(8'h55, 3'b100 >> j);
         expect_ev(1'b0, 8'h80 >> j, 1'b0);
         check(err_show, 1);
         key();
      end
      send_frame(8'h00, 8'h00, 1, 1'b1, 0);
      expect_ev(1'b0, 8'h02, 1'b0);
      check(err_show, 0);
      // Send timeout
      mark();
      @(negedge clk) tx_start = 1'b1;
      @(negedge clk) tx_start = 1'b0;
      repeat (TO - 2) @(negedge clk);
      #5 check(ev_n - e0, 0);
      expect_ev(1'b0, 8'h08, 1'b1);
      check(err_show, 1);
      key();
      // Reply to a sent command, then a char fault while sending
      @(negedge clk) tx_start = 1'b1;
      @(negedge clk) tx_start = 1'b0;
      send_frame(UNIT_EXPECTED, ACK_CODE, 1, 1'b0, 0);
      expect_ev(1'b1, 8'h00, 1'b0);
      check(cmd_len, frm.size());
      @(negedge clk) tx_start = 1'b1;
      @(negedge clk) tx_start = 1'b0;
      mark();
      host.send_char(8'h55, 3'b010);
      expect_ev(1'b0, 8'h40, 1'b1);
      check(err_dir, 1);
      host.send_char(END_CHAR, 3'b000);
      key();
      // Overflow of the receive store
      auto_reset = 1'b0;
      mark();
      host.send_char(START_CHAR, 3'b000);
      for (int i = 0; i < DP; i++) host.send_char(8'h81, 3'b000);
      host.send_char(END_CHAR, 3'b000);
      expect_ev(1'b0, 8'h10, 1'b0);
      check(hold_seen, 1);
      check(err_dir, 0);
      key();
      wrap_up();
   end
endmodule
`default_nettype wire
